// ===== rtl/lamp_if.sv
// Purpose: carries mode lamp indications between the core and the lamp driver
// Assumes: one clock domain
// Notes: red and green are separate lamp elements of one lamp
`timescale 1ns/100ps
`default_nettype none
interface lamp_if;
  import mode_select_pkg::*;
  op_mode_e mode;
  logic link_lost;
  logic placement_master;
  logic aut_green;
  logic man_green;
  logic adj_green;
  logic las_green;
  logic diag_green;
  logic diag_red;
  logic side_green;
  modport core (output mode, output link_lost, output placement_master,
                input aut_green, input man_green, input adj_green, input las_green,
                input diag_green, input diag_red, input side_green);
  modport lamps (input mode, input link_lost, input placement_master,
                 output aut_green, output man_green, output adj_green, output las_green,
                 output diag_green, output diag_red, output side_green);
endinterface
`default_nettype wire

// ===== rtl/mode_lamps.sv
// Purpose: registered drive of the operating-mode and placement lamps
// Assumes: inputs are flops in the core
// Notes: at most one mode lamp is lit at a time, none during reset
`timescale 1ns/100ps
`default_nettype none
module mode_lamps
  import mode_select_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // lamp carrier
  lamp_if.lamps lp
);

  // ----------------------------------------------------------------
  // lamp registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lp.aut_green <= 1'h0;
      lp.man_green <= 1'h0;
      lp.adj_green <= 1'h0;
      lp.las_green <= 1'h0;
      lp.diag_green <= 1'h0;
      lp.diag_red <= 1'h0;
      lp.side_green <= 1'h0;
    end else begin
      lp.aut_green <= (lp.mode == automatic_mode); // RULE_02
      lp.man_green <= (lp.mode == manual_align_mode); // RULE_05
      lp.adj_green <= (lp.mode == adjust_mode);
      lp.las_green <= (lp.mode == alignment_laser_mode); // RULE_10
      // dark outside diag mode, green clean, red once latched
      lp.diag_green <= (lp.mode == link_interruption_diag_mode) && !lp.link_lost; // RULE_11 RULE_12
      lp.diag_red <= (lp.mode == link_interruption_diag_mode) && lp.link_lost; // RULE_13
      lp.side_green <= lp.placement_master; // RULE_14
    end
  end

endmodule
`default_nettype wire

// ===== rtl/mode_select_indicator.sv
// Purpose: operating-mode selection, link-drop thresholds and mode indication
// Assumes: selector press is a synchronous one-cycle-or-longer level, edge detected here
// Notes: level inputs are bar segment counts 0..BAR_SEGMENTS
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// RULE_01 - each selector press steps to the next operating mode, wrapping round
// RULE_02 - automatic mode lamp lit green while automatic mode active
// RULE_03 - automatic mode is the standard mode and carries user data
// RULE_04 - automatic mode: link held until level drops below lowest orange segment
// RULE_05 - manual mode lamp lit green while manual alignment mode active
// RULE_06 - manual mode: link held only until level drops below lowest green segment
// RULE_07 - adjust mode blocks user data in both directions
// RULE_08 - adjust mode: link held until level drops below lowest orange segment
// RULE_09 - adjust mode sends own level to peer and shows peer level on bar
// RULE_10 - laser mode turns on alignment laser and its green lamp
// RULE_11 - diagnostic lamp dark whenever diagnostic mode is not active
// RULE_12 - diagnostic lamp green while no interruption seen since enabling
// RULE_13 - any interruption after enabling latches diagnostic lamp red
// RULE_14 - placement setting held; its lamp dark for slave, green for master
// RULE_15 - warning output raised when level falls into red and orange range
// RULE_16 - latched interruption flag cleared on entering diagnostic mode
module mode_select_indicator
  import mode_select_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // operator controls
  input wire logic mode_button,
  input wire logic placement_master_set,
  // received level and peer exchange
  input wire logic [LEVEL_W-1:0] own_level,
  input wire logic [LEVEL_W-1:0] peer_level,
  input wire logic signal_present,
  // user data gating and link
  output logic user_data_enable,
  output logic link_up,
  output logic send_level_to_peer,
  output logic [LEVEL_W-1:0] level_to_peer,
  output logic [LEVEL_W-1:0] received_level_bar,
  output logic warning_switch_output,
  // laser and lamps
  output logic alignment_laser_on,
  output logic [2:0] active_mode,
  output logic lamp_automatic,
  output logic lamp_manual,
  output logic lamp_adjust,
  output logic lamp_laser,
  output logic lamp_diag_green,
  output logic lamp_diag_red,
  output logic lamp_placement
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  op_mode_e mode_r;
  op_mode_e mode_nxt;
  logic button_d_r;
  logic link_up_r;
  logic link_lost_r;
  logic placement_r;
  logic press;
  logic link_hold;
  lamp_if lp ();

  // ----------------------------------------------------------------
  // mode decodes shared by several processes
  // ----------------------------------------------------------------
  function automatic logic in_adjust(input op_mode_e m);
    in_adjust = (m == adjust_mode);
  endfunction

  function automatic logic in_diag(input op_mode_e m);
    in_diag = (m == link_interruption_diag_mode);
  endfunction

  // ----------------------------------------------------------------
  // mode selector
  // ----------------------------------------------------------------
  assign press = mode_button && !button_d_r;

  // next mode in step order
  always_comb begin
    unique case (mode_r)
      automatic_mode: mode_nxt = manual_align_mode;
      manual_align_mode: mode_nxt = adjust_mode;
      adjust_mode: mode_nxt = alignment_laser_mode;
      alignment_laser_mode: mode_nxt = link_interruption_diag_mode;
      link_interruption_diag_mode: mode_nxt = automatic_mode;
      default: mode_nxt = MODE_RST;
    endcase
  end

  // edge memory of the selector
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      button_d_r <= 1'h0;
    end else begin
      button_d_r <= mode_button;
    end
  end

  // mode register steps once per press
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mode_r <= MODE_RST;
    end else if (press) begin
      mode_r <= mode_nxt; // RULE_01
    end
  end

  // placement setting follows the configuration control
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      placement_r <= PLACEMENT_RST;
    end else begin
      placement_r <= placement_master_set; // RULE_14
    end
  end

  // ----------------------------------------------------------------
  // optical link hold with mode dependent threshold
  // ----------------------------------------------------------------
  // link holds while level is at or above the mode's lowest segment
  assign link_hold = signal_present && (own_level >= drop_threshold(mode_r)); // RULE_04 RULE_06 RULE_08

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      link_up_r <= 1'h0;
    end else begin
      link_up_r <= link_hold;
    end
  end

  // interruption latch, cleared on entering diag mode, drop wins
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      link_lost_r <= 1'h0;
    end else if (in_diag(mode_r) && link_up_r && !link_hold) begin
      link_lost_r <= 1'h1; // RULE_13
    end else if (press && in_diag(mode_nxt)) begin
      link_lost_r <= 1'h0; // RULE_16
    end
  end

  // ----------------------------------------------------------------
  // data gating, level exchange, warning
  // ----------------------------------------------------------------
  // data carried on an up link except in adjust mode
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      user_data_enable <= 1'h0;
    end else begin
      user_data_enable <= link_hold && !in_adjust(mode_r); // RULE_03 RULE_07
    end
  end

  // own level offered to the peer, flagged only in adjust mode
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      send_level_to_peer <= 1'h0;
      level_to_peer <= '0;
    end else begin
      send_level_to_peer <= in_adjust(mode_r); // RULE_09
      level_to_peer <= own_level; // RULE_09
    end
  end

  // adjust mode shows the peer's level on the local bar
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      received_level_bar <= '0;
    end else begin
      received_level_bar <= in_adjust(mode_r) ? peer_level : own_level; // RULE_09
    end
  end

  // only red and orange lit: below lowest green segment
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      warning_switch_output <= 1'h0;
    end else begin
      warning_switch_output <= (own_level < LOWEST_GREEN_SEG); // RULE_15
    end
  end

  // alignment laser follows laser mode
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      alignment_laser_on <= 1'h0;
    end else begin
      alignment_laser_on <= (mode_r == alignment_laser_mode); // RULE_10
    end
  end

  // ----------------------------------------------------------------
  // lamp driver
  // ----------------------------------------------------------------
  assign lp.mode = mode_r;
  assign lp.link_lost = link_lost_r;
  assign lp.placement_master = placement_r;

  mode_lamps u_lamps (
    .clk(clk),
    .reset_n(reset_n),
    .lp(lp)
  );

  // outputs
  assign link_up = link_up_r;
  assign active_mode = mode_r;
  assign lamp_automatic = lp.aut_green;
  assign lamp_manual = lp.man_green;
  assign lamp_adjust = lp.adj_green;
  assign lamp_laser = lp.las_green;
  assign lamp_diag_green = lp.diag_green;
  assign lamp_diag_red = lp.diag_red;
  assign lamp_placement = lp.side_green;

endmodule
`default_nettype wire

// ===== rtl/mode_select_pkg.sv
// Purpose: shared constants and types for the mode selector and indicator block
// Assumes: single clock, synchronous active-low reset
// Notes: received level is a bar-segment count, zero means no light at all
package mode_select_pkg;

  // operating modes in selector step order
  typedef enum logic [2:0] {
    automatic_mode,
    manual_align_mode,
    adjust_mode,
    alignment_laser_mode,
    link_interruption_diag_mode
  } op_mode_e;

  // received_level_bar geometry
  localparam int unsigned LEVEL_W = 4;
  localparam logic [3:0] BAR_SEGMENTS = 4'ha;
  // lowest orange segment and lowest green segment, as bar positions
  localparam logic [3:0] LOWEST_ORANGE_SEG = 4'h3;
  localparam logic [3:0] LOWEST_GREEN_SEG = 4'h6;

  // reset values
  localparam op_mode_e MODE_RST = automatic_mode;
  localparam logic PLACEMENT_RST = 1'h0;

  // link drop threshold for a mode: level below it drops the link
  function automatic logic [3:0] drop_threshold(input op_mode_e m);
    drop_threshold = (m == manual_align_mode) ? LOWEST_GREEN_SEG : LOWEST_ORANGE_SEG;
  endfunction

endpackage

// ===== verif/mode_select_indicator_properties.sv
// Purpose: port assertions for the mode selector block
// Assumes: one clock, synchronous active-low reset
// Notes: bound from the bench top file
`timescale 1ns/100ps
`default_nettype none
module mode_select_indicator_properties (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // watched inputs
  input wire logic mode_button,
  input wire logic placement_master_set,
  input wire logic signal_present,
  input wire logic [3:0] own_level,
  // watched outputs
  input wire logic user_data_enable,
  input wire logic link_up,
  input wire logic send_level_to_peer,
  input wire logic lamp_automatic,
  input wire logic lamp_manual,
  input wire logic lamp_diag_green,
  input wire logic lamp_diag_red,
  input wire logic lamp_placement,
  input wire logic [2:0] active_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // selector stepping, mode lamps and adjust mode gating
  chk_mode_step: assert property (
    $rose(mode_button) |=> active_mode == ($past(active_mode) == 3'h4 ? 3'h0 : $past(active_mode) + 3'h1))
    else $error("mode step");
  chk_mode_lamps: assert property (
    $past(reset_n) |-> lamp_automatic == ($past(active_mode) == 3'h0) && lamp_manual == ($past(active_mode) == 3'h1))
    else $error("mode lamp");
  chk_adjust_gate: assert property (
    $past(reset_n) && $past(active_mode) == 3'h2 |-> !user_data_enable && send_level_to_peer) else $error("adjust gate");
  // link hold threshold per mode
  chk_link_hold: assert property (
    $past(reset_n) |-> link_up == ($past(signal_present) &&
    $past(own_level) >= ($past(active_mode) == 3'h1 ? 4'h6 : 4'h3))) else $error("link hold");
  // diagnostic and placement lamps
  chk_diag_dark: assert property (
    $past(reset_n) && $past(active_mode) != 3'h4 |-> !lamp_diag_green && !lamp_diag_red) else $error("diag dark");
  chk_diag_red: assert property (
    $past(active_mode) == 3'h4 && active_mode == 3'h4 && $fell(link_up) |=> lamp_diag_red) else $error("diag red");
  chk_diag_clear: assert property (
    $rose(active_mode == 3'h4) |=> lamp_diag_green && !lamp_diag_red) else $error("diag clear");
  chk_place_lamp: assert property (
    $past(reset_n) && $past(reset_n, 2) |-> lamp_placement == $past(placement_master_set, 2)) else $error("placement");
  cov_red: cover property ($rose(lamp_diag_red));
  cov_manual_drop: cover property (active_mode == 3'h1 && $fell(link_up));
  cov_adjust: cover property (active_mode == 3'h2 && link_up);
endmodule
`default_nettype wire

// ===== verif/mode_select_indicator_tb.sv
// Purpose: self-checking bench for the mode selector block
// Assumes: inputs change at the falling edge
// Notes: corner then random levels in every mode
`timescale 1ns/100ps
`default_nettype none
module mode_select_indicator_tb;
  import mode_select_pkg::*;
  logic clk = 0, reset_n = 0, mode_button = 0, placement_master_set = 0, signal_present = 1;
  logic [3:0] own_level = 4'h8, peer_own = 4'h4, peer_level, level_to_peer, received_level_bar;
  logic user_data_enable, link_up, send_level_to_peer, warning_switch_output, alignment_laser_on;
  logic lamp_automatic, lamp_manual, lamp_adjust, lamp_laser, lamp_diag_green, lamp_diag_red, lamp_placement;
  logic [2:0] active_mode;
  logic [3:0] corner [5] = '{4'ha, 4'h2, 4'h3, 4'h5, 4'h6};
  int error_cnt = 0, n_compared = 0;
  mode_select_indicator u_mode_select_indicator (
    .clk(clk),
    .reset_n(reset_n),
    .mode_button(mode_button),
    .placement_master_set(placement_master_set),
    .own_level(own_level),
    .peer_level(peer_level),
    .signal_present(signal_present),
    .user_data_enable(user_data_enable),
    .link_up(link_up),
    .send_level_to_peer(send_level_to_peer),
    .level_to_peer(level_to_peer),
    .received_level_bar(received_level_bar),
    .warning_switch_output(warning_switch_output),
    .alignment_laser_on(alignment_laser_on),
    .active_mode(active_mode),
    .lamp_automatic(lamp_automatic),
    .lamp_manual(lamp_manual),
    .lamp_adjust(lamp_adjust),
    .lamp_laser(lamp_laser),
    .lamp_diag_green(lamp_diag_green),
    .lamp_diag_red(lamp_diag_red),
    .lamp_placement(lamp_placement)
  );
  peer_model u_peer_model (
    .clk(clk),
    .send_level_to_peer(send_level_to_peer),
    .peer_own(peer_own),
    .peer_level(peer_level)
  );
  // clock
  always #2.5 clk = ~clk;
  task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask
  task automatic press(input int hold);
    @(negedge clk) mode_button = 1;
    repeat (hold) @(negedge clk);
    mode_button = 0;
    @(negedge clk);
  endtask
  function automatic logic exp_hold(input logic [2:0] m, input logic [3:0] l, input logic s);
    return s && l >= (m == 3'h1 ? LOWEST_GREEN_SEG : LOWEST_ORANGE_SEG);
  endfunction
  // one level for one edge, then the registered outputs
  task automatic step(input logic [3:0] l, input logic s);
    logic [2:0] m;
    logic [3:0] pl;
    own_level = l;
    signal_present = s;
    peer_own = 4'($urandom_range(10));
    m = active_mode;
    pl = peer_level;
    @(negedge clk);
    check("link", {3'h0, exp_hold(m, l, s)}, {3'h0, link_up});
    check("data", {3'h0, exp_hold(m, l, s) && m != 3'h2}, {3'h0, user_data_enable});
    check("warn", {3'h0, l < LOWEST_GREEN_SEG}, {3'h0, warning_switch_output});
    check("bar", m == 3'h2 ? pl : l, received_level_bar);
    check("to peer", l, level_to_peer);
    check("send", {3'h0, m == 3'h2}, {3'h0, send_level_to_peer});
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    void'($urandom(14245));
    repeat (8) @(negedge clk);
    reset_n = 1;
    repeat (2) @(negedge clk);
    check("lamps", 4'h8, {lamp_automatic, lamp_manual, lamp_adjust, lamp_laser});
    for (int i = 1; i < 6; i++) begin
      press(i);
      check("mode", 4'(i % 5), {1'b0, active_mode});
      check("lamps", 4'h8 >> (i % 5), {lamp_automatic, lamp_manual, lamp_adjust, lamp_laser});
      check("laser", {3'h0, i == 3}, {3'h0, alignment_laser_on});
      foreach (corner[k]) step(corner[k], 1);
      repeat (10) step(4'($urandom_range(10)), 1'($urandom_range(3) != 0));
    end
    $display("test modes done");
    step(4'h8, 1);
    repeat (4) press(1);
    check("diag", 4'h2, {2'h0, lamp_diag_green, lamp_diag_red});
    step(4'h8, 0);
    repeat (3) step(4'h8, 1);
    check("diag", 4'h1, {2'h0, lamp_diag_green, lamp_diag_red});
    $display("test diag done");
    for (int i = 0; i < 6; i++) begin
      placement_master_set = (i < 2) ? 1'(i) : 1'($urandom);
      repeat (2) @(negedge clk);
      check("place", {3'h0, placement_master_set}, {3'h0, lamp_placement});
    end
    reset_n = 0;
    repeat (2) @(negedge clk);
    reset_n = 1;
    repeat (2) @(negedge clk);
    check("lamps", 4'h8, {lamp_automatic, lamp_manual, lamp_adjust, lamp_laser});
    check("diag", 4'h0, {2'h0, lamp_diag_green, lamp_diag_red});
    $display("test placement done");
    test_done;
  end
  // cut a hang short
  initial begin
    #20000;
    error_cnt++;
    test_done;
  end
endmodule
bind mode_select_indicator mode_select_indicator_properties u_mode_select_indicator_properties (
  .clk(clk),
  .reset_n(reset_n),
  .mode_button(mode_button),
  .placement_master_set(placement_master_set),
  .signal_present(signal_present),
  .own_level(own_level),
  .user_data_enable(user_data_enable),
  .link_up(link_up),
  .send_level_to_peer(send_level_to_peer),
  .lamp_automatic(lamp_automatic),
  .lamp_manual(lamp_manual),
  .lamp_diag_green(lamp_diag_green),
  .lamp_diag_red(lamp_diag_red),
  .lamp_placement(lamp_placement),
  .active_mode(active_mode)
);
`default_nettype wire

// ===== verif/peer_model.sv
// Purpose: peer transceiver across the optical link
// Assumes: shares the bench clock
// Notes: level line toggles while no level is sent
`timescale 1ns/100ps
`default_nettype none
module peer_model (
  // link side
  input wire logic clk,
  input wire logic send_level_to_peer,
  input wire logic [3:0] peer_own,
  output logic [3:0] peer_level
);
  logic [3:0] pattern_r = 4'h5;
  // own level only while asked, else a changing pattern
  always @(posedge clk) pattern_r <= send_level_to_peer ? peer_own : ~pattern_r;
  assign peer_level = pattern_r;
endmodule
`default_nettype wire
